// File: vsr_pkg.sv
// Shared constants and types for the output voltage setpoint register block.
// Assumes a PMBus command decoder in front that presents decoded word accesses.
`default_nettype none

package vsr_pkg;

  // ********************************************************************
  // Command codes of the setpoint words
  // ********************************************************************
  localparam logic [7:0] CMD_OPERATION = 8'h01; // Operating state and margin select.
  localparam logic [7:0] CMD_VOUT_SET = 8'h21; // Nominal output voltage word.
  localparam logic [7:0] CMD_TRIM = 8'h22; // Factory trim word.
  localparam logic [7:0] CMD_CAL_OFS = 8'h23; // User calibration offset word.
  localparam logic [7:0] CMD_CEILING = 8'h24; // Upper voltage clamp word.
  localparam logic [7:0] CMD_MARGIN_HI = 8'h25; // Margin high setpoint word.
  localparam logic [7:0] CMD_MARGIN_LO = 8'h26; // Margin low setpoint word.

  // ********************************************************************
  // Field layout and reset values
  // ********************************************************************
  localparam int WORD_W = 16; // Every setpoint is a two-byte word.
  localparam int ONOFF_HI = 7; // Upper bit of the on/off field.
  localparam int ONOFF_LO = 6; // Lower bit of the on/off field.
  localparam int MARGIN_HI_BIT = 5; // Upper bit of the margin field.
  localparam int MARGIN_LO_BIT = 4; // Lower bit of the margin field.
  localparam logic [1:0] ONOFF_ON = 2'h2; // On/off field value meaning on.
  localparam logic [7:0] OPERATION_RST = 8'h00; // Immediate off at reset.
  localparam logic [15:0] TRIM_RST = 16'h0000; // Trim is zero at reset.
  localparam logic [15:0] CAL_OFS_RST = 16'h0000; // Calibration offset is zero at reset.
  // Default ratios against the strap voltage, as numerator over 100.
  localparam logic [7:0] CEILING_PCT = 8'h73; // 1.15 times the strap setting.
  localparam logic [7:0] MARGIN_HI_PCT = 8'h69; // 1.05 times the strap setting.
  localparam logic [7:0] MARGIN_LO_PCT = 8'h5F; // 0.95 times the strap setting.
  localparam logic [7:0] PCT_DIV = 8'h64; // Divisor of the ratios above.
  // Full-scale ceiling: 5.5 V at 2^-13 V per step.
  localparam logic [15:0] CEILING_LIMIT = 16'hB000;

  // Margin selection decoded from the operation byte.
  typedef enum logic [1:0] {
    VSR_NOMINAL = 2'b00,
    VSR_MARGIN_LOW = 2'b01,
    VSR_MARGIN_HIGH = 2'b10,
    VSR_OUTPUT_OFF = 2'b11
  } vsr_margin_t;

  // One decoded register access from the command decoder.
  typedef struct packed {
    logic wr; // Write strobe, one cycle.
    logic rd; // Read strobe, one cycle.
    logic [7:0] cmd; // Command code.
    logic [15:0] wdata; // Write word, low byte first on the wire.
  } vsr_req_t;

endpackage : vsr_pkg

`default_nettype wire

// File: vsr_setpoint_regs.sv
// Output voltage setpoint registers with per-page copies and target derivation.
// Assumes a PMBus command decoder on clk presenting one access per strobe
// and an already synchronised strap voltage setting.
`default_nettype none

// Summary of operation
// (R1) Trim word added to commanded voltage.
// (R2) Trim is signed, 2^-13 volts per step.
// (R3) Calibration offset added independently of trim.
// (R4) Calibration offset signed, 2^-13 volts.
// (R5) Ceiling bounds every commanded output voltage.
// (R6) Command above ceiling regulates at ceiling.
// (R7) Ceiling never rescaled by command changes.
// (R8) Ceiling unsigned, 1.15 strap by default, limited to 5.5 V; a written ceiling word is not limited.
// (R9) Margin high setpoint used, default 1.05 strap.
// (R10) Margin low setpoint used, default 0.95 strap.
// (R11) Separate copy of settings per page.
// (R12) Settings move as two-byte words.
// (R13) Operation bits select nominal or margin.
// (R14) Nominal target from unsigned command word.
// (R15) Target is setpoint plus offsets, clamped.

module vsr_setpoint_regs #(
  parameter int PAGES = 2, // Number of output pages.
  parameter int PAGE_W = 1 // Width of the page index.
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Command access from the PMBus decoder.
  input wire vsr_pkg::vsr_req_t req,
  input wire logic [PAGE_W-1:0] page,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic rmiss,
  // Strap voltage setting, 2^-13 volts per step.
  input wire logic [15:0] strap_voltage_setting,
  // Per-page effective targets and enables.
  output logic [PAGES*16-1:0] vout_target,
  output logic [PAGES-1:0] output_on
);

  // ********************************************************************
  // Default derivation from the strap setting
  // ********************************************************************

  // Scales the strap setting by pct/100, saturating at full scale.
  function automatic logic [15:0] scale_strap(input logic [15:0] v, input logic [7:0] pct);
    logic [23:0] prod;
    logic [23:0] quot;
    begin
      prod = {8'h00, v} * {16'h0000, pct};
      quot = prod / {16'h0000, vsr_pkg::PCT_DIV};
      scale_strap = (quot > 24'h00FFFF) ? 16'hFFFF : quot[15:0];
    end
  endfunction : scale_strap

  // Decodes the operation byte into the margin selection.
  function automatic vsr_pkg::vsr_margin_t decode_margin(input logic [7:0] op);
    begin
      if (op[vsr_pkg::ONOFF_HI:vsr_pkg::ONOFF_LO] != vsr_pkg::ONOFF_ON) begin
        decode_margin = vsr_pkg::VSR_OUTPUT_OFF;
      end else begin
        case (op[vsr_pkg::MARGIN_HI_BIT:vsr_pkg::MARGIN_LO_BIT]) // see (R13)
          2'b01: decode_margin = vsr_pkg::VSR_MARGIN_LOW;
          2'b10: decode_margin = vsr_pkg::VSR_MARGIN_HIGH;
          default: decode_margin = vsr_pkg::VSR_NOMINAL;
        endcase
      end
    end
  endfunction : decode_margin

  // Strap-derived defaults, computed combinationally.
  logic [15:0] ceil_dflt;
  logic [15:0] mhi_dflt;
  logic [15:0] mlo_dflt;
  logic [15:0] ceil_scaled;

  // Ceiling default limited to the 5.5 V full-scale value.
  always_comb begin
    ceil_scaled = scale_strap(strap_voltage_setting, vsr_pkg::CEILING_PCT);
    ceil_dflt = (ceil_scaled > vsr_pkg::CEILING_LIMIT) ? vsr_pkg::CEILING_LIMIT
                                                        : ceil_scaled; // see (R8)
    mhi_dflt = scale_strap(strap_voltage_setting, vsr_pkg::MARGIN_HI_PCT); // see (R9)
    mlo_dflt = scale_strap(strap_voltage_setting, vsr_pkg::MARGIN_LO_PCT); // see (R10)
  end

  // Strap captured one cycle after reset release, to load the defaults.
  logic load_dflt_r;

  // Marks the first cycle after reset so defaults load from the strap.
  always_ff @(posedge clk) begin
    if (srst) begin
      load_dflt_r <= 1'b1;
    end else begin
      load_dflt_r <= 1'b0;
    end
  end

  // ********************************************************************
  // Per-page storage
  // ********************************************************************
  logic [7:0] oper_r [PAGES];
  logic [15:0] strap_voltage_setting_r [PAGES];
  logic [15:0] trim_r [PAGES];
  logic [15:0] cal_r [PAGES];
  logic [15:0] ceil_r [PAGES];
  logic [15:0] mhi_r [PAGES];
  logic [15:0] mlo_r [PAGES];

  genvar gp;
  generate
    for (gp = 0; gp < PAGES; gp++) begin : g_page
      // Write strobe for this page.
      logic pw;
      assign pw = req.wr && (page == PAGE_W'(gp)); // see (R11)

      // Operation byte; not strap-dependent, resets to immediate off.
      always_ff @(posedge clk) begin
        if (srst) begin
          oper_r[gp] <= vsr_pkg::OPERATION_RST;
        end else if (pw && req.cmd == vsr_pkg::CMD_OPERATION) begin
          oper_r[gp] <= req.wdata[7:0];
        end
      end

      // Offset words, each independent of the others.
      always_ff @(posedge clk) begin
        if (srst) begin
          trim_r[gp] <= vsr_pkg::TRIM_RST;
          cal_r[gp] <= vsr_pkg::CAL_OFS_RST;
        end else if (pw) begin
          if (req.cmd == vsr_pkg::CMD_TRIM) begin
            trim_r[gp] <= req.wdata; // see (R12)
          end
          if (req.cmd == vsr_pkg::CMD_CAL_OFS) begin
            cal_r[gp] <= req.wdata; // see (R12)
          end
        end
      end

      // Strap-derived setpoints load once after reset, then follow writes.
      // A command write touches only its own word, so the ceiling keeps
      // its value whatever happens to the nominal setting.
      always_ff @(posedge clk) begin
        if (srst) begin
          strap_voltage_setting_r[gp] <= 16'h0000;
          ceil_r[gp] <= 16'h0000;
          mhi_r[gp] <= 16'h0000;
          mlo_r[gp] <= 16'h0000;
        end else if (load_dflt_r) begin
          strap_voltage_setting_r[gp] <= strap_voltage_setting;
          ceil_r[gp] <= ceil_dflt;
          mhi_r[gp] <= mhi_dflt;
          mlo_r[gp] <= mlo_dflt;
        end else if (pw) begin
          case (req.cmd)
            vsr_pkg::CMD_VOUT_SET: strap_voltage_setting_r[gp] <= req.wdata; // see (R7)
            vsr_pkg::CMD_CEILING: ceil_r[gp] <= req.wdata; // see (R8)
            vsr_pkg::CMD_MARGIN_HI: mhi_r[gp] <= req.wdata;
            vsr_pkg::CMD_MARGIN_LO: mlo_r[gp] <= req.wdata;
            default: ;
          endcase
        end
      end

      // ****************************************************************
      // Effective target of this page
      // ****************************************************************
      vsr_pkg::vsr_margin_t msel;
      logic [15:0] base;
      logic signed [18:0] sum;
      logic [15:0] tgt_nxt;
      logic [15:0] tgt_r;
      logic on_r;

      // Chooses the setpoint, adds both signed offsets, clamps the sum.
      always_comb begin
        msel = decode_margin(oper_r[gp]);
        case (msel)
          vsr_pkg::VSR_MARGIN_HIGH: base = mhi_r[gp]; // see (R9)
          vsr_pkg::VSR_MARGIN_LOW: base = mlo_r[gp]; // see (R10)
          default: base = strap_voltage_setting_r[gp]; // see (R14)
        endcase
        sum = $signed({3'b000, base}) + 19'($signed(trim_r[gp])) // see (R1) (R2)
            + 19'($signed(cal_r[gp])); // see (R3) (R4)
        if (sum < 19'sd0) begin
          tgt_nxt = 16'h0000;
        end else if (sum > $signed({3'b000, ceil_r[gp]})) begin
          tgt_nxt = ceil_r[gp]; // see (R5) (R6) (R15)
        end else begin
          tgt_nxt = sum[15:0];
        end
      end

      // Registers the target and the on state.
      always_ff @(posedge clk) begin
        if (srst) begin
          tgt_r <= 16'h0000;
          on_r <= 1'b0;
        end else begin
          tgt_r <= tgt_nxt;
          on_r <= (msel != vsr_pkg::VSR_OUTPUT_OFF);
        end
      end

      assign vout_target[gp*16 +: 16] = tgt_r;
      assign output_on[gp] = on_r;

      // Target never exceeds the ceiling of its page.
      target_ceiling_a: assert property (@(posedge clk) disable iff (srst) // see (R5)
        !$past(srst) |-> tgt_r <= $past(ceil_r[gp]))
        else $error("Target above ceiling.");

      // Nominal selection with zero offsets follows the command word.
      nominal_follow_a: assert property (@(posedge clk) disable iff (srst) // see (R14)
        (msel == vsr_pkg::VSR_NOMINAL && trim_r[gp] == 16'h0000 && cal_r[gp] == 16'h0000
         && strap_voltage_setting_r[gp] <= ceil_r[gp]) |=> tgt_r == $past(strap_voltage_setting_r[gp]))
        else $error("Nominal target mismatch.");

      // Margin high with zero offsets gives the margin high word.
      margin_high_a: assert property (@(posedge clk) disable iff (srst) // see (R9)
        (msel == vsr_pkg::VSR_MARGIN_HIGH && trim_r[gp] == 16'h0000
         && cal_r[gp] == 16'h0000 && mhi_r[gp] <= ceil_r[gp]) |=> tgt_r == $past(mhi_r[gp]))
        else $error("Margin high target mismatch.");

      // Margin low with zero offsets gives the margin low word.
      margin_low_a: assert property (@(posedge clk) disable iff (srst) // see (R10)
        (msel == vsr_pkg::VSR_MARGIN_LOW && trim_r[gp] == 16'h0000
         && cal_r[gp] == 16'h0000 && mlo_r[gp] <= ceil_r[gp]) |=> tgt_r == $past(mlo_r[gp]))
        else $error("Margin low target mismatch.");

      // Operation code 0x80 selects nominal, 0x90 low, 0xA0 high.
      margin_decode_a: assert property (@(posedge clk) disable iff (srst) // see (R13)
        (oper_r[gp] == 8'hA0 |-> msel == vsr_pkg::VSR_MARGIN_HIGH)
        and (oper_r[gp] == 8'h90 |-> msel == vsr_pkg::VSR_MARGIN_LOW)
        and (oper_r[gp] == 8'h80 |-> msel == vsr_pkg::VSR_NOMINAL))
        else $error("Margin decode wrong.");

      // Writing the command word leaves the ceiling unchanged.
      ceiling_kept_a: assert property (@(posedge clk) disable iff (srst || load_dflt_r) // see (R7)
        (pw && req.cmd == vsr_pkg::CMD_VOUT_SET) |=> $stable(ceil_r[gp]))
        else $error("Ceiling moved on command write.");

      // A trim of one step raises an unclamped nominal target by one.
      trim_step_a: assert property (@(posedge clk) disable iff (srst) // see (R1)
        (msel == vsr_pkg::VSR_NOMINAL && trim_r[gp] == 16'h0001 && cal_r[gp] == 16'h0000
         && strap_voltage_setting_r[gp] < ceil_r[gp]) |=> tgt_r == $past(strap_voltage_setting_r[gp]) + 16'h0001)
        else $error("Trim not applied.");

      // A calibration offset of minus one step lowers the target by one.
      cal_step_a: assert property (@(posedge clk) disable iff (srst) // see (R3)
        (msel == vsr_pkg::VSR_NOMINAL && cal_r[gp] == 16'hFFFF && trim_r[gp] == 16'h0000
         && strap_voltage_setting_r[gp] != 16'h0000 && strap_voltage_setting_r[gp] <= ceil_r[gp])
        |=> tgt_r == $past(strap_voltage_setting_r[gp]) - 16'h0001)
        else $error("Calibration offset not applied.");
    end
  endgenerate

  // ********************************************************************
  // Read-back
  // ********************************************************************
  logic [15:0] rword;
  logic rhit;

  // Selects the addressed word of the current page.
  always_comb begin
    rhit = 1'b1;
    case (req.cmd)
      vsr_pkg::CMD_OPERATION: rword = {8'h00, oper_r[page]};
      vsr_pkg::CMD_VOUT_SET: rword = strap_voltage_setting_r[page];
      vsr_pkg::CMD_TRIM: rword = trim_r[page];
      vsr_pkg::CMD_CAL_OFS: rword = cal_r[page];
      vsr_pkg::CMD_CEILING: rword = ceil_r[page];
      vsr_pkg::CMD_MARGIN_HI: rword = mhi_r[page];
      vsr_pkg::CMD_MARGIN_LO: rword = mlo_r[page];
      default: begin
        rword = 16'h0000;
        rhit = 1'b0;
      end
    endcase
  end

  // Answers a read one cycle after the strobe, as a full two-byte word.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      rmiss <= 1'b0;
    end else begin
      rvalid <= req.rd;
      rmiss <= req.rd && !rhit;
      if (req.rd) begin
        rdata <= rword; // see (R12) (R11)
      end
    end
  end

  // A read strobe is answered exactly one cycle later.
  read_answer_a: assert property (@(posedge clk) disable iff (srst) // see (R12)
    req.rd |=> rvalid)
    else $error("Read not answered.");

  // Without a read strobe no answer appears in the next cycle.
  read_quiet_a: assert property (@(posedge clk) disable iff (srst) // see (R12)
    !req.rd |=> !rvalid && !rmiss)
    else $error("Answer without a read.");

endmodule : vsr_setpoint_regs

`default_nettype wire

// File: vsr_host_model.sv
// Host model that issues decoded word accesses to the setpoint register block.
// Assumes the bench calls its tasks, and that every request starts at a falling edge.
`default_nettype none

module vsr_host_model (
  // Clock.
  input wire logic clk,
  // Decoded access toward the block.
  output vsr_pkg::vsr_req_t req,
  output logic [0:0] page,
  // Read answer from the block.
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic rmiss
);
  timeunit 1ns;
  timeprecision 1ps;

  // Nothing is requested before the bench asks for it.
  initial begin
    req = '0;
    page = 1'b0;
  end

  // Released fields show the inverse of the last value, so a stale word never looks valid.
  task automatic idle();
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.wdata = ~req.wdata;
    req.cmd = ~req.cmd;
    page = ~page;
  endtask : idle

  // Sends one whole two-byte word, held for exactly one sampling edge.
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data, input logic p);
    @(negedge clk);
    req.wr = 1'b1;
    req.cmd = cmd;
    req.wdata = data;
    page = p;
    @(negedge clk);
    idle();
  endtask : write_word

  // Asks for one word and takes the answer in the cycle after the strobe.
  task automatic read_word(input logic [7:0] cmd, input logic p, output logic [15:0] d,
                           output logic v, output logic m);
    @(negedge clk);
    req.rd = 1'b1;
    req.cmd = cmd;
    page = p;
    @(negedge clk);
    d = rdata;
    v = rvalid;
    m = rmiss;
    idle();
  endtask : read_word

endmodule : vsr_host_model

`default_nettype wire

// File: test_vsr_setpoint_regs.sv
// Self-checking bench for the output voltage setpoint register block.
// Assumes vsr_pkg, vsr_setpoint_regs and vsr_host_model are compiled before it.
`default_nettype none

module test_vsr_setpoint_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************************************************
  // Signals and reference model
  // ********************************************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] strap = 16'h0000;
  vsr_pkg::vsr_req_t req;
  logic [0:0] page;
  logic [15:0] rdata;
  logic rvalid;
  logic rmiss;
  logic [31:0] vout_target;
  logic [1:0] output_on;
  logic [15:0] mw [2][7]; // Reference copy of every word, per page.
  logic [7:0] codes [7]; // Command code of each reference slot.
  integer seed = 89;
  int n_fail = 0;
  int n_compared = 0;
  logic [15:0] rd_w;
  logic rd_v;
  logic rd_m;

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  vsr_host_model u_host (.clk(clk), .req(req), .page(page), .rdata(rdata), .rvalid(rvalid),
    .rmiss(rmiss));
  vsr_setpoint_regs u_dut (.clk(clk), .srst(srst), .req(req), .page(page), .rdata(rdata),
    .rvalid(rvalid), .rmiss(rmiss), .strap_voltage_setting(strap), .vout_target(vout_target),
    .output_on(output_on));

  // Compares a word result.
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp16

  // Compares a flag result.
  task automatic cmp1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  // Selected setpoint plus signed offsets, kept within zero and the ceiling.
  function automatic logic [15:0] exp_target(input int p);
    int s;
    logic on;
    on = (mw[p][0][7:6] == 2'h2);
    s = mw[p][1];
    if (on && mw[p][0][5:4] == 2'h1) s = mw[p][6];
    if (on && mw[p][0][5:4] == 2'h2) s = mw[p][5];
    s = s + int'($signed(mw[p][2])) + int'($signed(mw[p][3]));
    if (s < 0) s = 0;
    if (s > int'(mw[p][4])) s = int'(mw[p][4]);
    return 16'(s);
  endfunction : exp_target

  // Checks the target and the on state of both pages.
  task automatic check_targets();
    for (int p = 0; p < 2; p++) begin
      cmp16("vout_target", exp_target(p), vout_target[p*16+:16]);
      cmp1("output_on", mw[p][0][7:6] == 2'h2, output_on[p]);
    end
  endtask : check_targets

  // Reads back every word of every page.
  task automatic check_all();
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 7; k++) begin
        u_host.read_word(codes[k], 1'(p), rd_w, rd_v, rd_m);
        cmp16("rdata", mw[p][k], rd_w);
        cmp1("rvalid", 1'b1, rd_v);
        cmp1("rmiss", 1'b0, rd_m);
      end
    end
    check_targets();
  endtask : check_all

  // Writes one word through the host and records it in the reference copy.
  task automatic put_word(input int k, input logic [15:0] d, input logic pg);
    u_host.write_word(codes[k], d, pg);
    mw[pg][k] = d;
  endtask : put_word

  // Fills the reference copy with the defaults that follow a reset.
  task automatic load_defaults();
    int sv;
    int ceil_v;
    int mhi_v;
    sv = int'(strap);
    ceil_v = sv * 115 / 100;
    if (ceil_v > int'(vsr_pkg::CEILING_LIMIT)) ceil_v = int'(vsr_pkg::CEILING_LIMIT);
    mhi_v = sv * 105 / 100;
    if (mhi_v > 32'h0000FFFF) mhi_v = 32'h0000FFFF;
    for (int p = 0; p < 2; p++) begin
      mw[p] = '{16'h0000, strap, 16'h0000, 16'h0000, 16'(ceil_v), 16'(mhi_v), 16'(sv * 95 / 100)};
    end
  endtask : load_defaults

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Cuts a hang short, well beyond the roughly 800 cycles the tests need.
  initial begin
    #200000;
    n_fail++;
    $display("watchdog expired");
    complete_run();
  end

  // Main sequence, driven on falling edges.
  initial begin
    int k;
    logic [15:0] d;
    logic pg;
    logic [15:0] ops [6];
    ops = '{16'h0000, 16'h0040, 16'h0080, 16'h0090, 16'h00A0, 16'h00B0};
    codes = '{vsr_pkg::CMD_OPERATION, vsr_pkg::CMD_VOUT_SET, vsr_pkg::CMD_TRIM,
              vsr_pkg::CMD_CAL_OFS, vsr_pkg::CMD_CEILING, vsr_pkg::CMD_MARGIN_HI,
              vsr_pkg::CMD_MARGIN_LO};
    // A strap high enough that the ceiling default hits its full-scale clamp.
    strap = 16'hA000 + 16'({$random(seed)} % 8192);
    repeat (2) @(negedge clk);
    srst = 1'b0;
    load_defaults();
    check_all();
    $display("test defaults done");
    for (int i = 0; i < 150; i++) begin
      k = {$random(seed)} % 7;
      pg = 1'($random(seed));
      d = 16'($random(seed));
      if (k == 0) d = ops[{$random(seed)} % 6];
      if (k == 2 || k == 3) d = 16'($random(seed) % 1229);
      put_word(k, d, pg);
      u_host.read_word(codes[k], pg, rd_w, rd_v, rd_m);
      cmp16("rdata", mw[pg][k], rd_w);
      check_targets();
    end
    $display("test random writes done");
    // Zero offsets through every operating state, then single steps of each offset.
    for (int p = 0; p < 2; p++) begin
      put_word(2, 16'h0000, 1'(p));
      put_word(3, 16'h0000, 1'(p));
      put_word(4, vsr_pkg::CEILING_LIMIT, 1'(p));
      put_word(1, 16'({$random(seed)} % 32'h0000A000) + 16'h0001, 1'(p));
      put_word(5, 16'({$random(seed)} % 32'h0000A000), 1'(p));
      put_word(6, 16'({$random(seed)} % 32'h0000A000), 1'(p));
      for (int j = 0; j < 6; j++) begin
        put_word(0, ops[j], 1'(p));
        @(negedge clk);
        check_targets();
      end
      put_word(0, 16'h0080, 1'(p));
      put_word(2, 16'h0001, 1'(p));
      @(negedge clk);
      check_targets();
      put_word(2, 16'h0000, 1'(p));
      put_word(3, 16'hFFFF, 1'(p));
      @(negedge clk);
      check_targets();
      put_word(3, 16'h0000, 1'(p));
      put_word(1, 16'hFFFF, 1'(p));
      @(negedge clk);
      check_targets();
    end
    $display("test directed settings done");
    u_host.write_word(8'h27, 16'h5A5A, 1'b0);
    u_host.read_word(8'h27, 1'b0, rd_w, rd_v, rd_m);
    cmp1("rmiss", 1'b1, rd_m);
    cmp16("rdata", 16'h0000, rd_w);
    check_all();
    $display("test unmapped done");
    // A reset in mid-run with a new strap clears the target and reloads every default.
    srst = 1'b1;
    strap = 16'({$random(seed)} % 32'h0000A000);
    repeat (2) @(negedge clk);
    cmp16("reset vout_target", 16'h0000, vout_target[15:0]);
    srst = 1'b0;
    load_defaults();
    check_all();
    $display("test mid-run reset done");
    complete_run();
  end

endmodule : test_vsr_setpoint_regs

`default_nettype wire
